// ### verilog/dee_consts.svh
// Operation
// - After a good unlock, only the next accepted access can be the start write.
// - Unlock key register is write-only, guarding data against accidents.
// - Bit 15 starts a cycle; software sets it, hardware clears it.
// - Bit 14 must be set to run a cycle; cleared when done.
// - Bit 13 set when pin or watchdog reset aborts a cycle.
// - Bit 12 set skips the automatic erase before a write.
// - Bit 6 selects erase when 1, write when 0.
// - Erase codes 011010, 011001, 011000 erase eight, four, one words.
// - Erase code 0100xx erases the whole array.
// - Write code 0001xx programs one word at the captured address.
// - Control bits 11 to 7 read as zero.
// - Last table write address captured into high and low parts; table writes made while a cycle runs are not captured.
// - Captured low address bit 0 always reads zero.
// - Captured high address bit 7 always reads zero.
// - Array spans 7ffe00h to 7fffffh, 256 words.
// - Array is 16 bits wide; only the low table word matters.
// - Cycles run in the background and never stall the bus.
// - Table writes load the latch and the target address; ignored while a cycle runs.
// - Undefined operation codes do nothing when started.
// - Completion sets the completion flag.
`ifndef DEE_CONSTS_SVH
`define DEE_CONSTS_SVH
// Register byte addresses
`define DEE_ADDR_CTRL 5'h00
`define DEE_ADDR_KEY 5'h04
`define DEE_ADDR_ADRL 5'h08
`define DEE_ADDR_ADRH 5'h0c
`define DEE_ADDR_TABLE_PAGE_POINTER 5'h10
`define DEE_ADDR_TBLDAT 5'h14
`define DEE_ADDR_STAT 5'h18
// Control bit positions
`define DEE_B_GO 15
`define DEE_B_WEN 14
`define DEE_B_ABORT 13
`define DEE_B_SKIP 12
`define DEE_B_ERASE 6
// Keys
`define DEE_KEY1 8'h55
`define DEE_KEY2 8'haa
// Operation code patterns
`define DEE_OP_ER8 6'h1a
`define DEE_OP_ER4 6'h19
`define DEE_OP_ER1 6'h18
`define DEE_OP_BULK_HI 4'h4
`define DEE_OP_WR_HI 4'h1
// Window: 7ffe00h .. 7fffffh
`define DEE_WIN_BASE 15'h3fff
`define DEE_WORDS 256
// Cycle timing
`define DEE_ERASE_NS 4000
`define DEE_PROG_NS 4000
`define DEE_CLK_NS 40
`endif

// ### verilog/dee_pkg.sv
package dee_pkg;
  typedef enum logic [2:0] {
    DEE_NONE, DEE_ER1, DEE_ER4, DEE_ER8, DEE_BULK, DEE_WR
  } dee_op_t;
  typedef enum {ST_IDLE, ST_ERASE, ST_PROG} dee_state_t;
endpackage

// ### verilog/dee_array.sv
`timescale 1ns/1ps
`default_nettype none
// Storage array, one 16-bit word per index; erase sets words to ffff
module dee_array (
  input wire logic sys_clk_i,
  input wire logic [7:0] rd_idx_i,
  output logic [15:0] rd_data_o,
  input wire logic [7:0] er_lo_i,
  input wire logic [7:0] er_hi_i,
  input wire logic er_en_i,
  input wire logic [7:0] wr_idx_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_en_i
);
  logic [15:0] mem_q [0:255];
  // Nonvolatile contents are not cleared by reset
  genvar g;
  generate
    for (g = 0; g < 256; g = g + 1) begin : g_word
      always_ff @(posedge sys_clk_i) begin
        if (er_en_i && 8'(g) >= er_lo_i && 8'(g) <= er_hi_i) begin
          mem_q[g] <= 16'hffff;
        end else if (wr_en_i && wr_idx_i == 8'(g)) begin
          mem_q[g] <= mem_q[g] & wr_data_i;
        end
      end
    end
  endgenerate
  assign rd_data_o = mem_q[rd_idx_i];
endmodule
`default_nettype wire

// ### verilog/dee_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.svh"
module dee_ctrl (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic abort_rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic busy_o,
  output logic completion_int_flag_o
);
  import dee_pkg::*;

  // Bus contract: a write is taken at the first edge at which it stands.
  // A read holds waitrequest for one cycle while the word is registered,
  // and is taken at the second edge with the data standing there.
  // No other wait state exists, so a running erase or program cycle
  // never slows software down.
  // The unlock opens the next accepted access only, read or write;
  // anything but the start write in that slot closes it again.
  // Abort pulses come from another reset domain and pass two flops.
  localparam int ERASE_CYC =
    (`DEE_ERASE_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS;
  localparam int PROG_CYC = (`DEE_PROG_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS;

  logic [15:0] ctrl_q;
  logic [1:0] key_q;
  logic unlock_q;
  logic [7:0] adrh_q;
  logic [15:0] adrl_q;
  logic [15:0] latch_q;
  logic [7:0] table_page_pointer_q;
  logic cif_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  dee_state_t state_q;
  logic [7:0] cnt_q;
  dee_op_t op_q;
  logic abort_s1_q;
  logic abort_s2_q;
  logic [15:0] arr_rd;
  logic wr_acc;
  logic rd_acc;
  logic start;
  logic done;
  logic er_en;
  logic wr_en;
  logic [7:0] er_lo;
  logic [7:0] er_hi;
  logic [7:0] word_idx;
  logic rd_done;
  dee_op_t op_dec;

  // Decode the command from erase select and operation code
  function automatic dee_op_t decode_op(input logic erase,
                                        input logic [5:0] code);
    if (erase && code == `DEE_OP_ER8) decode_op = DEE_ER8;
    else if (erase && code == `DEE_OP_ER4) decode_op = DEE_ER4;
    else if (erase && code == `DEE_OP_ER1) decode_op = DEE_ER1;
    else if (erase && code[5:2] == `DEE_OP_BULK_HI)
      decode_op = DEE_BULK;
    else if (!erase && code[5:2] == `DEE_OP_WR_HI)
      decode_op = DEE_WR;
    else decode_op = DEE_NONE;
  endfunction

  // Reset pin from outside the domain is synchronised first
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      abort_s1_q <= 1'b0;
      abort_s2_q <= 1'b0;
    end else begin
      abort_s1_q <= abort_rst_i;
      abort_s2_q <= abort_s1_q;
    end
  end

  // Reads wait one cycle for registered data; busy cycles add nothing
  assign avs_waitrequest_o = rd_acc && !rvalid_q;
  assign wr_acc = avs_write_i;
  assign rd_acc = avs_read_i && !avs_write_i;
  assign rd_done = rd_acc && rvalid_q;
  assign op_dec = decode_op(ctrl_q[`DEE_B_ERASE], ctrl_q[5:0]);
  assign word_idx = adrl_q[8:1];

  // Read wait flag: high in the second cycle of a read only
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_acc && !rvalid_q;
    end
  end

  // Start only on an unlocked control write with go and enable set
  assign start = wr_acc && avs_address_i == `DEE_ADDR_CTRL
                 && unlock_q && avs_byteenable_i[1]
                 && avs_writedata_i[`DEE_B_GO]
                 && avs_writedata_i[`DEE_B_WEN]
                 && state_q == ST_IDLE;

  // Unlock sequence: 55h then aah arms the next accepted access only.
  // Counting accesses, not clocks, keeps the slot independent of how
  // many idle cycles the master leaves between two transfers.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      key_q <= 2'b00;
      unlock_q <= 1'b0;
    end else if (wr_acc || rd_done) begin
      unlock_q <= 1'b0;
      key_q <= 2'b00;
      if (wr_acc && avs_address_i == `DEE_ADDR_KEY) begin
        if (avs_writedata_i[7:0] == `DEE_KEY1) begin
          key_q <= 2'b01;
        end else if (avs_writedata_i[7:0] == `DEE_KEY2
                     && key_q == 2'b01) begin
          unlock_q <= 1'b1;
        end
      end
    end
  end

  // Control register; only the go bit needs the unlock window
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      ctrl_q <= 16'h0000;
    end else begin
      if (wr_acc && avs_address_i == `DEE_ADDR_CTRL) begin
        if (avs_byteenable_i[0] && state_q == ST_IDLE) begin
          ctrl_q[`DEE_B_ERASE] <= avs_writedata_i[`DEE_B_ERASE];
          ctrl_q[5:0] <= avs_writedata_i[5:0];
        end
        if (avs_byteenable_i[1] && state_q == ST_IDLE) begin
          ctrl_q[`DEE_B_SKIP] <= avs_writedata_i[`DEE_B_SKIP];
          ctrl_q[`DEE_B_WEN] <= avs_writedata_i[`DEE_B_WEN];
          ctrl_q[`DEE_B_ABORT] <= avs_writedata_i[`DEE_B_ABORT];
        end
      end
      if (start) begin
        ctrl_q[`DEE_B_GO] <= 1'b1;
      end
      if (done) begin
        ctrl_q[`DEE_B_GO] <= 1'b0;
        ctrl_q[`DEE_B_WEN] <= 1'b0;
        ctrl_q[`DEE_B_ABORT] <= 1'b0;
      end
      if (abort_s2_q && state_q != ST_IDLE) begin
        ctrl_q[`DEE_B_GO] <= 1'b0;
        ctrl_q[`DEE_B_WEN] <= 1'b0;
        ctrl_q[`DEE_B_ABORT] <= 1'b1;
      end
    end
  end

  // Table page, write latch and captured address
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      table_page_pointer_q <= 8'h00;
      adrh_q <= 8'h00;
      adrl_q <= 16'h0000;
      latch_q <= 16'h0000;
    end else if (wr_acc && avs_address_i == `DEE_ADDR_TABLE_PAGE_POINTER) begin
      table_page_pointer_q <= avs_writedata_i[7:0];
    end else if (wr_acc && avs_address_i == `DEE_ADDR_TBLDAT
                 && state_q == ST_IDLE) begin
      // High half carries the offset, low half the data word
      latch_q <= avs_writedata_i[15:0];
      adrh_q <= {1'b0, table_page_pointer_q[6:0]};
      adrl_q <= {avs_writedata_i[31:17], 1'b0};
    end
  end

  // Erase range for the current command
  always_comb begin
    er_lo = word_idx;
    er_hi = word_idx;
    case (op_q)
      DEE_ER4: begin
        er_lo = {word_idx[7:2], 2'b00};
        er_hi = {word_idx[7:2], 2'b11};
      end
      DEE_ER8: begin
        er_lo = {word_idx[7:3], 3'b000};
        er_hi = {word_idx[7:3], 3'b111};
      end
      DEE_BULK: begin
        er_lo = 8'h00;
        er_hi = 8'hff;
      end
      default: begin
        er_lo = word_idx;
        er_hi = word_idx;
      end
    endcase
  end

  // Only addresses inside the array window act on storage, except a bulk erase
  logic in_win;
  assign in_win = {adrh_q, adrl_q[15:9]} == `DEE_WIN_BASE;

  // Self-timed cycle: erase phase unless skipped, then program phase for a write
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      op_q <= DEE_NONE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start && op_dec != DEE_NONE) begin
            op_q <= op_dec;
            cnt_q <= 8'h00;
            if (op_dec == DEE_WR && ctrl_q[`DEE_B_SKIP]) begin
              state_q <= ST_PROG;
            end else begin
              state_q <= ST_ERASE;
            end
          end
        end
        ST_ERASE: begin
          if (abort_s2_q) begin
            state_q <= ST_IDLE;
          end else if (cnt_q == 8'(ERASE_CYC - 1)) begin
            cnt_q <= 8'h00;
            state_q <= (op_q == DEE_WR) ? ST_PROG : ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        ST_PROG: begin
          if (abort_s2_q) begin
            state_q <= ST_IDLE;
          end else if (cnt_q == 8'(PROG_CYC - 1)) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // A started undefined code finishes at once with no action
  assign done = !abort_s2_q && (
    (start && op_dec == DEE_NONE) ||
    (state_q == ST_ERASE && cnt_q == 8'(ERASE_CYC - 1)
     && op_q != DEE_WR) ||
    (state_q == ST_PROG && cnt_q == 8'(PROG_CYC - 1)));
  assign er_en = state_q == ST_ERASE && cnt_q == 8'(ERASE_CYC - 1)
                 && !abort_s2_q && (in_win || op_q == DEE_BULK);
  assign wr_en = state_q == ST_PROG && cnt_q == 8'(PROG_CYC - 1)
                 && !abort_s2_q && in_win;

  // Completion flag: set wins over a software clear
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      cif_q <= 1'b0;
    end else if (done) begin
      cif_q <= 1'b1;
    end else if (wr_acc && avs_address_i == `DEE_ADDR_STAT
                 && avs_writedata_i[0]) begin
      cif_q <= 1'b0;
    end
  end

  dee_array u_array (
    .sys_clk_i(sys_clk_i),
    .rd_idx_i(word_idx),
    .rd_data_o(arr_rd),
    .er_lo_i(er_lo),
    .er_hi_i(er_hi),
    .er_en_i(er_en),
    .wr_idx_i(word_idx),
    .wr_data_i(latch_q),
    .wr_en_i(wr_en)
  );

  // Read data, registered in the wait cycle so it stands when taken.
  // Captured address is a read-only view: only a table write moves it.
  // Key reads zero and unmapped reads zero.
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_acc && !rvalid_q) begin
      if (avs_address_i == `DEE_ADDR_CTRL) begin
        rdata_q <= {16'h0000, ctrl_q[15:12], 5'h00, ctrl_q[6:0]};
      end else if (avs_address_i == `DEE_ADDR_KEY) begin
        rdata_q <= 32'h0000_0000;
      end else if (avs_address_i == `DEE_ADDR_ADRL) begin
        rdata_q <= {16'h0000, adrl_q};
      end else if (avs_address_i == `DEE_ADDR_ADRH) begin
        rdata_q <= {24'h000000, adrh_q};
      end else if (avs_address_i == `DEE_ADDR_TABLE_PAGE_POINTER) begin
        rdata_q <= {24'h000000, table_page_pointer_q};
      end else if (avs_address_i == `DEE_ADDR_TBLDAT) begin
        rdata_q <= {16'h0000, arr_rd};
      end else if (avs_address_i == `DEE_ADDR_STAT) begin
        rdata_q <= {31'h0, cif_q};
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata_o = rdata_q;
  assign busy_o = state_q != ST_IDLE;
  assign completion_int_flag_o = cif_q;
endmodule
`default_nettype wire

// ### bench/dee_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.svh"
module dee_ctrl_props (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic abort_rst_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic busy_o,
  input wire logic completion_int_flag_o
);
  localparam int MAX_BUSY = 400;
  logic wr_ok, rd_ok, hit_q, armed_q, ab_q;
  logic [8:0] busy_cnt_q;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  assign rd_ok = avs_read_i && !avs_waitrequest_o;
  // Unlock tracker; any accepted access after the second key closes it
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hit_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (wr_ok || rd_ok) begin
      hit_q <= wr_ok && avs_address_i == 5'(`DEE_ADDR_KEY) &&
               avs_writedata_i[7:0] == `DEE_KEY1;
      armed_q <= hit_q && wr_ok && avs_address_i == 5'(`DEE_ADDR_KEY) &&
                 avs_writedata_i[7:0] == `DEE_KEY2;
    end
  end
  // Cycle length, and whether an abort cut the running cycle short
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !busy_o) begin
      busy_cnt_q <= 9'h000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 9'h001;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i || !busy_o) begin
      ab_q <= 1'b0;
    end else if (abort_rst_i) begin
      ab_q <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  a_go_locked_out: assert property (wr_ok && !armed_q && !busy_o &&
    avs_address_i == 5'(`DEE_ADDR_CTRL) && avs_writedata_i[15]
    |=> !busy_o[*2]) else $error("cycle started without unlock");
  a_done_sets_flag: assert property ($fell(busy_o) && !ab_q
    |-> ##[0:2] completion_int_flag_o) else $error("no completion flag");
  a_busy_bounded: assert property (busy_cnt_q < 9'(MAX_BUSY))
    else $error("cycle never ends");
  a_ctrl_gap_zero: assert property (rd_ok &&
    avs_address_i == 5'(`DEE_ADDR_CTRL) |-> avs_readdata_o[11:7] == 5'h00)
    else $error("unimplemented control bits not zero");
  a_adrl_even: assert property (rd_ok &&
    avs_address_i == 5'(`DEE_ADDR_ADRL) |-> !avs_readdata_o[0])
    else $error("low address odd");
  a_adrh_msb_zero: assert property (rd_ok &&
    avs_address_i == 5'(`DEE_ADDR_ADRH) |-> !avs_readdata_o[7])
    else $error("high address msb set");
  a_key_write_only: assert property (rd_ok &&
    avs_address_i == 5'(`DEE_ADDR_KEY) |-> avs_readdata_o == 32'h0)
    else $error("key register readable");
  a_no_bus_stall: assert property (busy_o && (avs_read_i || avs_write_i)
    |-> ##[0:4] !avs_waitrequest_o) else $error("bus stalled in cycle");
  a_go_shows_busy: assert property (rd_ok && busy_o && $past(busy_o, 2) &&
    avs_address_i == 5'(`DEE_ADDR_CTRL) |-> avs_readdata_o[15])
    else $error("start bit low while busy");
endmodule
bind dee_ctrl dee_ctrl_props dee_ctrl_props_i (
  .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .abort_rst_i(abort_rst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .busy_o(busy_o),
  .completion_int_flag_o(completion_int_flag_o));
`default_nettype wire

// ### bench/dee_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dee_cpu_model (
  input wire logic sys_clk_i,
  input wire logic avs_waitrequest_i,
  input wire logic [31:0] avs_readdata_i,
  output logic [4:0] avs_address_o,
  output logic avs_read_o,
  output logic avs_write_o,
  output logic [3:0] avs_byteenable_o,
  output logic [31:0] avs_writedata_o
);
  // Idle bus at time zero; full word lanes since the array is one word wide
  initial begin
    avs_address_o = 5'h00;
    avs_read_o = 1'b0;
    avs_write_o = 1'b0;
    avs_byteenable_o = 4'hf;
    avs_writedata_o = 32'h0;
  end
  // One access; held until waitrequest is seen low, then one idle cycle
  task automatic xfer(input logic wr, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    avs_address_o <= a;
    avs_write_o <= wr;
    avs_read_o <= !wr;
    avs_writedata_o <= d;
    do @(posedge sys_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~d; // Released data must not look still valid
    @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

// ### bench/test_dee_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dee_consts.svh"
module test_dee_ctrl;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic abort_rst_i = 1'b0;
  logic [4:0] adr;
  logic rd, wr, wreq, busy, flag;
  logic [3:0] be;
  logic [31:0] wd, rdat, q;
  logic [15:0] seed = 16'h0043;
  logic [15:0] off, dat;
  logic [6:0] op;
  logic [6:0] ops [5] = '{7'h5a, 7'h59, 7'h58, 7'h50, 7'h04};
  int fail_count = 0;
  int n_compared = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  dee_ctrl dee_ctrl_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .abort_rst_i(abort_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(be), .avs_writedata_i(wd),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .busy_o(busy),
    .completion_int_flag_o(flag));
  dee_cpu_model dee_cpu_model_i (.sys_clk_i(sys_clk_i),
    .avs_waitrequest_i(wreq), .avs_readdata_i(rdat), .avs_address_o(adr),
    .avs_read_o(rd), .avs_write_o(wr), .avs_byteenable_o(be),
    .avs_writedata_o(wd));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Control word with writes enabled, start bit clear
  function automatic logic [15:0] cfg(input logic [6:0] o, input logic sk);
    return {2'b01, 1'b0, sk, 5'h00, o};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr32(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] x;
    dee_cpu_model_i.xfer(1'b1, a, d, x);
  endtask
  task automatic rd32(input logic [4:0] a);
    dee_cpu_model_i.xfer(1'b0, a, 32'h0, q);
  endtask
  // Configure, unlock with both keys in order, then set the start bit
  task automatic go(input logic [15:0] c);
    wr32(`DEE_ADDR_CTRL, {16'h0, c});
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY1});
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY2});
    wr32(`DEE_ADDR_CTRL, {16'h0, c | 16'h8000});
  endtask
  // Poll until the cycle ends; software stays off the array meanwhile
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 600) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk("cycle end", {31'h0, busy}, 32'h0);
  endtask
  task automatic idle_chk(input string nm);
    repeat (3) @(posedge sys_clk_i);
    chk(nm, {31'h0, busy}, 32'h0);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog far beyond the longest expected run
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd32(`DEE_ADDR_CTRL);
    chk("ctrl reset", q, 32'h0);
    rd32(`DEE_ADDR_KEY);
    chk("key read", q, 32'h0);
    wr32(`DEE_ADDR_CTRL, 32'hcfd8);
    idle_chk("start no keys");
    rd32(`DEE_ADDR_CTRL);
    chk("ctrl gap", {27'h0, q[11:7]}, 32'h0);
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY2});
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY1});
    wr32(`DEE_ADDR_CTRL, 32'hc058);
    idle_chk("start keys swapped");
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY1});
    wr32(`DEE_ADDR_KEY, {24'h0, `DEE_KEY2});
    wr32(`DEE_ADDR_TABLE_PAGE_POINTER, 32'hff);
    wr32(`DEE_ADDR_CTRL, 32'hc058);
    idle_chk("start late");
    go(16'h0058);
    idle_chk("start disabled");
    go(cfg(7'h7f, 1'b0));
    idle_chk("start bad code");
    // Every command at a random word of the window, odd offsets included
    for (int i = 0; i < 5; i++) begin
      seed = lfsr(seed);
      off = 16'hfe00 | {7'h0, seed[8:0]};
      dat = lfsr(seed);
      op = ops[i] | {5'h0, (i >= 3) ? seed[1:0] : 2'b00};
      wr32(`DEE_ADDR_TABLE_PAGE_POINTER, 32'hff);
      wr32(`DEE_ADDR_TBLDAT, {off, dat});
      rd32(`DEE_ADDR_ADRL);
      chk("addr low", q, {16'h0, off[15:1], 1'b0});
      rd32(`DEE_ADDR_ADRH);
      chk("addr high", q, 32'h7f);
      wr32(`DEE_ADDR_STAT, 32'h1);
      chk("flag clear", {31'h0, flag}, 32'h0);
      go(cfg(op, seed[9] & !op[6]));
      chk("busy", {31'h0, busy}, 32'h1);
      rd32(`DEE_ADDR_CTRL);
      chk("start bit", {31'h0, q[15]}, 32'h1);
      wait_idle();
      chk("done flag", {31'h0, flag}, 32'h1);
      rd32(`DEE_ADDR_CTRL);
      chk("ctrl after", q, {19'h0, seed[9] & !op[6], 5'h0, op});
      rd32(`DEE_ADDR_TBLDAT);
      chk("word", {16'h0, q[15:0]}, {16'h0, op[6] ? 16'hffff : dat});
    end
    go(cfg(7'h04, 1'b0));
    repeat (3) @(posedge sys_clk_i);
    abort_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    abort_rst_i <= 1'b0;
    wait_idle();
    rd32(`DEE_ADDR_CTRL);
    chk("abort flag", {31'h0, q[13]}, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire
